/* logic/xmd_decoder.sv */
// Extended memory address decoder: picks one target per access, registered.
// Assumes configuration is quasi-static and requests are synchronous to i_sys_clk.
`default_nettype none

// Operation
// (R1) Accesses from 1 MB to top of main memory go to memory, except the hole.
// (R2) Enabled fixed hole sends 15-16 MB to the hub link; memory behind is lost.
// (R3) APIC space never relocated; no hardware cap on memory size.
// (R4) Graphics enabled reserves 1 MB, 512 K or 8 MB at top of memory.
// (R5) SMM processor hits on high segment remap into the legacy video range.
// (R6) Non-SMM processor hits on SMM segments terminate, write-backs go to SMM space.
// (R7) Hub or AGP cycles to enabled SMM space are refused.
// (R8) Top segment sits just above usable memory; SMM accesses keep their address.
// (R9) Extended SMM size comes from the SMM size field.
// (R10) Downstream accesses in extended SMM range go to the hub link.
// (R11) Top of memory to 4 GB defaults to the hub link.
// (R12) Impedance compensation registers above memory are claimed internally.
// (R13) Internal graphics mode sends its config and mapped ranges to the graphics unit.
// (R14) AGP mode sends base/limit window hits to the AGP port.
// (R15) AGP mode sends graphics aperture hits to main memory.
// (R16) Software keeps graphics, AGP and aperture windows off APIC and high BIOS.
// (R17) I/O interrupt-controller range goes to the hub link, 16 units of 4 KB.
// (R18) Gap between APIC space and high BIOS always goes to the hub link; enabled high SMM segment hits in it are decoded first.
// (R19) Top 2 MB, the high BIOS, goes to the hub link.
// (R20) Window registers give address bits 31:20, 1 MB granular.
// (R21) Each AGP window claims base <= address <= limit, tested independently.
// (R22) AGP windows route only while the bridge memory enable is set.
// (R23) Compatible SMM: SMM processor video-range accesses hit memory, others video.
// (R24) Exactly one target; SMM and internal first, then graphics, then hub; AGP windows are checked after main memory, APIC, gap and BIOS.
module xmd_decoder #(
    parameter logic [31:0] HIGH_SMM_SEGMENT_BASE     = 32'hFEDA_0000,
    parameter logic [32:0] IMPEDANCE_COMPENSATION_BYTES   = 33'h0_0000_1000,
    parameter logic [32:0] IGD_CFG_BYTES = 33'h0_0000_1000,
    parameter logic [32:0] IGD_MMIO_SZ   = 33'h0_0008_0000
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic             i_valid,
    input  wire xmd_pkg::xmd_req_t i_req,
    input  wire xmd_pkg::xmd_cfg_t i_cfg,
    output logic                  o_valid,
    output xmd_pkg::xmd_rsp_t     o_rsp
);

    // High segment must align to the 128 KB video window it folds into
    if (HIGH_SMM_SEGMENT_BASE[xmd_pkg::HIGH_SMM_SEGMENT_OFS_W-1:0] != '0) begin : g_bad_high_smm_segment
        $error("xmd_decoder: HIGH_SMM_SEGMENT_BASE not 128 KB aligned");
    end
    if (IMPEDANCE_COMPENSATION_BYTES == '0 || IGD_CFG_BYTES == '0 || IGD_MMIO_SZ == '0) begin : g_bad_sz
        $error("xmd_decoder: window sizes must be non-zero");
    end

    logic [32:0]              top_of_system_memory;
    logic [32:0]              gfx_sz;
    logic [32:0]              top_smm_segment_sz;
    logic [32:0]              gfx_base;
    logic [32:0]              top_smm_segment_base;
    logic [32:0]              addr_d;
    logic [32:0]              rg_base  [xmd_pkg::RG_NUM];
    logic [32:0]              rg_limit [xmd_pkg::RG_NUM];
    logic [xmd_pkg::RG_NUM-1:0] rg_en;
    logic [xmd_pkg::RG_NUM-1:0] rg_hit;
    logic                     is_cpu;
    logic                     smm_hit;
    logic                     nxt_valid;
    xmd_pkg::xmd_rsp_t        nxt_rsp;
    logic                     o_valid_ff;
    xmd_pkg::xmd_rsp_t        o_rsp_ff;

    assign addr_d = {1'b0, i_req.addr};
    assign is_cpu = (i_req.src == xmd_pkg::XMD_SRC_CPU);

    // Layout from the top of memory downward: graphics, then top SMM segment
    always_comb begin
        top_of_system_memory = {i_cfg.top_of_main_memory_mb, xmd_pkg::LOW_ZERO};
        gfx_sz = xmd_pkg::SZ_ZERO;
        if (i_cfg.gfx_en) begin // R4
            case (i_cfg.gfx_sel)
                xmd_pkg::GFX_SEL_1MB:  gfx_sz = xmd_pkg::SZ_1MB;
                xmd_pkg::GFX_SEL_512K: gfx_sz = xmd_pkg::SZ_512K;
                xmd_pkg::GFX_SEL_8MB:  gfx_sz = xmd_pkg::SZ_8MB;
                default:               gfx_sz = xmd_pkg::SZ_1MB;
            endcase
        end
        top_smm_segment_sz = xmd_pkg::SZ_ZERO;
        if (i_cfg.top_smm_segment_en) begin
            case (i_cfg.smm_size) // R9
                xmd_pkg::SMM_SZ_128K: top_smm_segment_sz = xmd_pkg::SZ_128K;
                xmd_pkg::SMM_SZ_256K: top_smm_segment_sz = xmd_pkg::SZ_256K;
                xmd_pkg::SMM_SZ_512K: top_smm_segment_sz = xmd_pkg::SZ_512K;
                xmd_pkg::SMM_SZ_1MB:  top_smm_segment_sz = xmd_pkg::SZ_1MB;
                default:              top_smm_segment_sz = xmd_pkg::SZ_1MB;
            endcase
        end
        gfx_base  = top_of_system_memory - gfx_sz;
        top_smm_segment_base = gfx_base - top_smm_segment_sz; // R8
    end

    // Range table; the 33rd bit keeps 4 GB limits from wrapping
    always_comb begin
        rg_base[xmd_pkg::RG_MAIN]      = {1'b0, xmd_pkg::EXT_BASE};
        rg_limit[xmd_pkg::RG_MAIN]     = top_smm_segment_base - xmd_pkg::ONE_D; // R1 R3
        // A wrapped layout (regions larger than memory) must not open a 4 GB main range
        rg_en[xmd_pkg::RG_MAIN]        = (top_smm_segment_base > {1'b0, xmd_pkg::EXT_BASE})
                                         && (top_smm_segment_base <= top_of_system_memory);
        rg_base[xmd_pkg::RG_HOLE]      = {1'b0, xmd_pkg::HOLE_BASE};
        rg_limit[xmd_pkg::RG_HOLE]     = {1'b0, xmd_pkg::HOLE_LIMIT};
        rg_en[xmd_pkg::RG_HOLE]        = i_cfg.fixed_hole_en; // R2
        rg_base[xmd_pkg::RG_GFX]       = gfx_base;
        rg_limit[xmd_pkg::RG_GFX]      = top_of_system_memory - xmd_pkg::ONE_D;
        rg_en[xmd_pkg::RG_GFX]         = i_cfg.gfx_en && (gfx_sz <= top_of_system_memory); // R4
        rg_base[xmd_pkg::RG_TOP_SMM_SEGMENT]      = top_smm_segment_base;
        rg_limit[xmd_pkg::RG_TOP_SMM_SEGMENT]     = gfx_base - xmd_pkg::ONE_D;
        rg_en[xmd_pkg::RG_TOP_SMM_SEGMENT]        = i_cfg.top_smm_segment_en && (top_smm_segment_sz <= gfx_base); // R8
        rg_base[xmd_pkg::RG_HIGH_SMM_SEGMENT]      = {1'b0, HIGH_SMM_SEGMENT_BASE};
        rg_limit[xmd_pkg::RG_HIGH_SMM_SEGMENT]     = {1'b0, HIGH_SMM_SEGMENT_BASE} + xmd_pkg::SZ_128K - xmd_pkg::ONE_D;
        rg_en[xmd_pkg::RG_HIGH_SMM_SEGMENT]        = i_cfg.high_smm_segment_en;
        rg_base[xmd_pkg::RG_VGA]       = {1'b0, xmd_pkg::VGA_BASE};
        rg_limit[xmd_pkg::RG_VGA]      = {1'b0, xmd_pkg::VGA_LIMIT};
        rg_en[xmd_pkg::RG_VGA]         = 1'b1;
        rg_base[xmd_pkg::RG_IMPEDANCE_COMPENSATION]     = {1'b0, i_cfg.impedance_compensation_base};
        rg_limit[xmd_pkg::RG_IMPEDANCE_COMPENSATION]    = {1'b0, i_cfg.impedance_compensation_base} + IMPEDANCE_COMPENSATION_BYTES - xmd_pkg::ONE_D;
        rg_en[xmd_pkg::RG_IMPEDANCE_COMPENSATION]       = ({1'b0, i_cfg.impedance_compensation_base} >= top_of_system_memory); // R12
        rg_base[xmd_pkg::RG_IGD_CFG]   = {1'b0, i_cfg.igd_cfg_base};
        rg_limit[xmd_pkg::RG_IGD_CFG]  = {1'b0, i_cfg.igd_cfg_base} + IGD_CFG_BYTES
                                         - xmd_pkg::ONE_D;
        rg_en[xmd_pkg::RG_IGD_CFG]     = i_cfg.igd_mode; // R13
        rg_base[xmd_pkg::RG_IGD_MMIO]  = {1'b0, i_cfg.igd_mmio_base};
        rg_limit[xmd_pkg::RG_IGD_MMIO] = {1'b0, i_cfg.igd_mmio_base} + IGD_MMIO_SZ
                                         - xmd_pkg::ONE_D;
        rg_en[xmd_pkg::RG_IGD_MMIO]    = i_cfg.igd_mode; // R13
        rg_base[xmd_pkg::RG_APER]      = {1'b0, i_cfg.aper_base};
        rg_limit[xmd_pkg::RG_APER]     = {1'b0, i_cfg.aper_base}
                                         + {1'b0, i_cfg.aper_mb, xmd_pkg::LOW_ZERO}
                                         - xmd_pkg::ONE_D;
        rg_en[xmd_pkg::RG_APER]        = i_cfg.agp_mode && (i_cfg.aper_mb != '0); // R15
        rg_base[xmd_pkg::RG_AGP_MEM]   = {1'b0, i_cfg.win_base, xmd_pkg::LOW_ZERO}; // R20
        rg_limit[xmd_pkg::RG_AGP_MEM]  = {1'b0, i_cfg.win_limit, xmd_pkg::LOW_ONES}; // R20
        rg_en[xmd_pkg::RG_AGP_MEM]     = i_cfg.agp_mode && i_cfg.agp_mem_en; // R22
        rg_base[xmd_pkg::RG_AGP_PF]    = {1'b0, i_cfg.pf_base, xmd_pkg::LOW_ZERO}; // R20
        rg_limit[xmd_pkg::RG_AGP_PF]   = {1'b0, i_cfg.pf_limit, xmd_pkg::LOW_ONES}; // R20
        rg_en[xmd_pkg::RG_AGP_PF]      = i_cfg.agp_mode && i_cfg.agp_mem_en; // R22
        rg_base[xmd_pkg::RG_IOAPIC]    = {1'b0, xmd_pkg::APIC_BASE};
        rg_limit[xmd_pkg::RG_IOAPIC]   = {1'b0, xmd_pkg::IOAPIC_LIMIT};
        rg_en[xmd_pkg::RG_IOAPIC]      = 1'b1;
        rg_base[xmd_pkg::RG_APIC]      = {1'b0, xmd_pkg::APIC_BASE};
        rg_limit[xmd_pkg::RG_APIC]     = {1'b0, xmd_pkg::APIC_LIMIT};
        rg_en[xmd_pkg::RG_APIC]        = 1'b1;
        rg_base[xmd_pkg::RG_GAP]       = {1'b0, xmd_pkg::GAP_BASE};
        rg_limit[xmd_pkg::RG_GAP]      = {1'b0, xmd_pkg::GAP_LIMIT};
        rg_en[xmd_pkg::RG_GAP]         = 1'b1;
        rg_base[xmd_pkg::RG_BIOS]      = {1'b0, xmd_pkg::BIOS_BASE};
        rg_limit[xmd_pkg::RG_BIOS]     = {1'b0, xmd_pkg::BIOS_LIMIT};
        rg_en[xmd_pkg::RG_BIOS]        = 1'b1;
    end

    // Each window is compared on its own, so overlaps never hide a hit
    for (genvar g = 0; g < xmd_pkg::RG_NUM; g++) begin : g_rng
        xmd_range_cmp #(
            .W (xmd_pkg::DEC_W)
        ) u_cmp (
            .i_addr  (addr_d),
            .i_base  (rg_base[g]),
            .i_limit (rg_limit[g]),
            .i_en    (rg_en[g]),
            .o_hit   (rg_hit[g])  // R21
        );
    end

    assign smm_hit = rg_hit[xmd_pkg::RG_HIGH_SMM_SEGMENT] || rg_hit[xmd_pkg::RG_TOP_SMM_SEGMENT];

    // One priority chain yields exactly one target per access
    always_comb begin
        nxt_valid = i_valid;
        nxt_rsp = xmd_pkg::RSP_RST;
        nxt_rsp.target = xmd_pkg::XMD_TGT_HUB; // R11
        nxt_rsp.addr = i_req.addr;
        if (addr_d < {1'b0, xmd_pkg::EXT_BASE}) begin
            if (rg_hit[xmd_pkg::RG_VGA]) begin
                if (i_cfg.compat_smm_en && is_cpu && i_req.smm) begin
                    nxt_rsp.target = xmd_pkg::XMD_TGT_MEM; // R23
                end else if (i_cfg.igd_mode) begin
                    nxt_rsp.target = xmd_pkg::XMD_TGT_IGD; // R23
                end else begin
                    nxt_rsp.target = xmd_pkg::XMD_TGT_HUB; // R23
                end
            end else if (addr_d < {1'b0, xmd_pkg::VGA_BASE}) begin
                nxt_rsp.target = xmd_pkg::XMD_TGT_MEM;
            end
        end else if (smm_hit) begin // R24
            if (is_cpu && (i_req.smm || i_req.writeback)) begin
                nxt_rsp.target = xmd_pkg::XMD_TGT_MEM; // R6 R8
                if (rg_hit[xmd_pkg::RG_HIGH_SMM_SEGMENT]) begin
                    // Physical memory behind the high segment is never reached
                    nxt_rsp.addr = {xmd_pkg::VGA_BASE[31:xmd_pkg::HIGH_SMM_SEGMENT_OFS_W],
                                    i_req.addr[xmd_pkg::HIGH_SMM_SEGMENT_OFS_W-1:0]}; // R5
                end
            end else if (is_cpu) begin
                nxt_rsp.target = xmd_pkg::XMD_TGT_NONE; // R6
                nxt_rsp.terminate = 1'b1; // R6
            end else begin
                nxt_rsp.target = xmd_pkg::XMD_TGT_HUB; // R10
                nxt_rsp.refused = 1'b1; // R7
            end
        end else if (rg_hit[xmd_pkg::RG_IMPEDANCE_COMPENSATION]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_INTERNAL; // R12
        end else if (rg_hit[xmd_pkg::RG_IGD_CFG] || rg_hit[xmd_pkg::RG_IGD_MMIO]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_IGD; // R13
        end else if (rg_hit[xmd_pkg::RG_GFX]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_IGD; // R4
        end else if (rg_hit[xmd_pkg::RG_HOLE]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_HUB; // R2
        end else if (rg_hit[xmd_pkg::RG_MAIN]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_MEM; // R1
        end else if (rg_hit[xmd_pkg::RG_APIC]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_HUB; // R17
            if (rg_hit[xmd_pkg::RG_IOAPIC]) begin
                nxt_rsp.ioapic_unit = i_req.addr[xmd_pkg::IOAPIC_UNIT_LSB
                                      +: xmd_pkg::IOAPIC_UNIT_W]; // R17
            end
        end else if (rg_hit[xmd_pkg::RG_GAP]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_HUB; // R18
        end else if (rg_hit[xmd_pkg::RG_BIOS]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_HUB; // R19
        end else if (rg_hit[xmd_pkg::RG_APER]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_MEM; // R15
        end else if (rg_hit[xmd_pkg::RG_AGP_MEM] || rg_hit[xmd_pkg::RG_AGP_PF]) begin
            nxt_rsp.target = xmd_pkg::XMD_TGT_AGP; // R14
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_valid_ff <= 1'b0;
        end else begin
            o_valid_ff <= nxt_valid;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rsp_ff <= xmd_pkg::RSP_RST;
        end else begin
            o_rsp_ff <= nxt_rsp;
        end
    end

    assign o_valid = o_valid_ff;
    assign o_rsp   = o_rsp_ff;

    // Checks
    logic [31:0] chk_addr;
    logic        chk_hi_pri;
    assign chk_addr   = i_req.addr;
    assign chk_hi_pri = smm_hit || rg_hit[xmd_pkg::RG_IMPEDANCE_COMPENSATION] || rg_hit[xmd_pkg::RG_IGD_CFG]
                        || rg_hit[xmd_pkg::RG_IGD_MMIO] || rg_hit[xmd_pkg::RG_GFX]
                        || (addr_d < {1'b0, xmd_pkg::EXT_BASE});

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_cpu_nonsmm_seg;
        i_valid && is_cpu && !i_req.smm && !i_req.writeback && smm_hit
        && (addr_d >= {1'b0, xmd_pkg::EXT_BASE});
    endsequence
    sequence s_terminated;
        o_valid && o_rsp.terminate && (o_rsp.target == xmd_pkg::XMD_TGT_NONE);
    endsequence

    AST_LATENCY: assert property (i_valid |=> o_valid) // R24
        else $error("response missing one cycle after request");
    AST_QUIET: assert property (!i_valid |=> !o_valid) // R24
        else $error("response without request");
    AST_SMM_TERM: assert property (s_cpu_nonsmm_seg |=> s_terminated) // R6
        else $error("non-SMM processor access to SMM segment not terminated");
    AST_REFUSE: assert property (i_valid && !is_cpu && smm_hit // R7
        && !(addr_d < {1'b0, xmd_pkg::EXT_BASE})
        |=> o_rsp.refused && o_rsp.target == xmd_pkg::XMD_TGT_HUB)
        else $error("downstream access to SMM space not refused");
    AST_HIGH_SMM_SEGMENT_REMAP: assert property (i_valid && is_cpu && i_req.smm // R5
        && rg_hit[xmd_pkg::RG_HIGH_SMM_SEGMENT] |=> o_rsp.target == xmd_pkg::XMD_TGT_MEM
        && o_rsp.addr == {xmd_pkg::VGA_BASE[31:17], $past(chk_addr[16:0])})
        else $error("high segment access not folded into video range");
    AST_TOP_SMM_SEGMENT_SAME: assert property (i_valid && is_cpu && i_req.smm // R8
        && rg_hit[xmd_pkg::RG_TOP_SMM_SEGMENT] && !rg_hit[xmd_pkg::RG_HIGH_SMM_SEGMENT]
        && (addr_d >= {1'b0, xmd_pkg::EXT_BASE})
        |=> o_rsp.target == xmd_pkg::XMD_TGT_MEM && o_rsp.addr == $past(chk_addr))
        else $error("top segment SMM access moved or misrouted");
    AST_AGP_GATE: assert property (i_valid && !i_cfg.agp_mem_en // R22
        |=> o_rsp.target != xmd_pkg::XMD_TGT_AGP)
        else $error("AGP window routed while memory enable clear");
    AST_IOAPIC_UNIT: assert property (i_valid && !chk_hi_pri // R17
        && !rg_hit[xmd_pkg::RG_MAIN]
        && !rg_hit[xmd_pkg::RG_HOLE] && rg_hit[xmd_pkg::RG_IOAPIC]
        |=> o_rsp.target == xmd_pkg::XMD_TGT_HUB
        && o_rsp.ioapic_unit == $past(chk_addr[15:12]))
        else $error("interrupt controller slot decoded wrong");
    AST_BIOS: assert property (i_valid && !chk_hi_pri && !rg_hit[xmd_pkg::RG_MAIN] // R19
        && chk_addr[31:21] == 11'h7FF |=> o_rsp.target == xmd_pkg::XMD_TGT_HUB)
        else $error("high BIOS not sent to hub link");
    AST_MAIN: assert property (i_valid && !chk_hi_pri && !rg_hit[xmd_pkg::RG_HOLE] // R1
        && rg_hit[xmd_pkg::RG_MAIN] |=> o_rsp.target == xmd_pkg::XMD_TGT_MEM)
        else $error("main memory access not sent to memory");
    AST_HOLE: assert property (i_valid && i_cfg.fixed_hole_en && !chk_hi_pri // R2
        && chk_addr[31:20] == 12'h00F |=> o_rsp.target == xmd_pkg::XMD_TGT_HUB)
        else $error("fixed hole not forwarded to hub link");
    AST_VGA_SMM: assert property (i_valid && rg_hit[xmd_pkg::RG_VGA] // R23
        && !(i_cfg.compat_smm_en && is_cpu && i_req.smm)
        |=> o_rsp.target != xmd_pkg::XMD_TGT_MEM)
        else $error("non-SMM video access reached memory");

endmodule // xmd_decoder

`default_nettype wire

/* logic/xmd_pkg.sv */
// Shared constants, encodings and carrier structs for the extended memory decoder.
// Assumes a 32-bit physical address space and one system clock domain.
`default_nettype none

package xmd_pkg;

    localparam int ADDR_W = 32;
    localparam int DEC_W  = 33;

    // Region sizes in the 33-bit decode arithmetic
    localparam logic [32:0] SZ_ZERO = 33'h0_0000_0000;
    localparam logic [32:0] SZ_128K = 33'h0_0002_0000;
    localparam logic [32:0] SZ_256K = 33'h0_0004_0000;
    localparam logic [32:0] SZ_512K = 33'h0_0008_0000;
    localparam logic [32:0] SZ_1MB  = 33'h0_0010_0000;
    localparam logic [32:0] SZ_8MB  = 33'h0_0080_0000;
    localparam logic [32:0] ONE_D   = 33'h0_0000_0001;

    // Fixed address map
    localparam logic [31:0] EXT_BASE     = 32'h0010_0000;
    localparam logic [31:0] VGA_BASE     = 32'h000A_0000;
    localparam logic [31:0] VGA_LIMIT    = 32'h000B_FFFF;
    localparam logic [31:0] HOLE_BASE    = 32'h00F0_0000;
    localparam logic [31:0] HOLE_LIMIT   = 32'h00FF_FFFF;
    localparam logic [31:0] APIC_BASE    = 32'hFEC0_0000;
    localparam logic [31:0] APIC_LIMIT   = 32'hFECF_FFFF;
    localparam logic [31:0] IOAPIC_LIMIT = 32'hFEC0_FFFF;
    localparam logic [31:0] GAP_BASE     = 32'hFED0_0000;
    localparam logic [31:0] GAP_LIMIT    = 32'hFFDF_FFFF;
    localparam logic [31:0] BIOS_BASE    = 32'hFFE0_0000;
    localparam logic [31:0] BIOS_LIMIT   = 32'hFFFF_FFFF;

    // Window granularity: low 20 bits of base are zero, of limit are ones
    localparam logic [19:0] LOW_ZERO = 20'h0_0000;
    localparam logic [19:0] LOW_ONES = 20'hF_FFFF;

    // Field positions
    localparam int IOAPIC_UNIT_LSB = 12;
    localparam int IOAPIC_UNIT_W   = 4;
    localparam int HIGH_SMM_SEGMENT_OFS_W      = 17;

    // Pre-allocated graphics size select
    localparam logic [1:0] GFX_SEL_1MB  = 2'h0;
    localparam logic [1:0] GFX_SEL_512K = 2'h1;
    localparam logic [1:0] GFX_SEL_8MB  = 2'h2;

    // SMM size field codes
    localparam logic [1:0] SMM_SZ_128K = 2'h0;
    localparam logic [1:0] SMM_SZ_256K = 2'h1;
    localparam logic [1:0] SMM_SZ_512K = 2'h2;
    localparam logic [1:0] SMM_SZ_1MB  = 2'h3;

    // Range table indices
    localparam int RG_MAIN     = 0;
    localparam int RG_HOLE     = 1;
    localparam int RG_GFX      = 2;
    localparam int RG_TOP_SMM_SEGMENT     = 3;
    localparam int RG_HIGH_SMM_SEGMENT     = 4;
    localparam int RG_VGA      = 5;
    localparam int RG_IMPEDANCE_COMPENSATION    = 6;
    localparam int RG_IGD_CFG  = 7;
    localparam int RG_IGD_MMIO = 8;
    localparam int RG_APER     = 9;
    localparam int RG_AGP_MEM  = 10;
    localparam int RG_AGP_PF   = 11;
    localparam int RG_IOAPIC   = 12;
    localparam int RG_APIC     = 13;
    localparam int RG_GAP      = 14;
    localparam int RG_BIOS     = 15;
    localparam int RG_NUM      = 16;

    typedef enum logic [1:0] {
        XMD_SRC_CPU = 2'h0,
        XMD_SRC_HUB = 2'h1,
        XMD_SRC_AGP = 2'h2
    } xmd_src_t;

    typedef enum logic [2:0] {
        XMD_TGT_MEM      = 3'h0,
        XMD_TGT_HUB      = 3'h1,
        XMD_TGT_IGD      = 3'h2,
        XMD_TGT_AGP      = 3'h3,
        XMD_TGT_INTERNAL = 3'h4,
        XMD_TGT_NONE     = 3'h5
    } xmd_tgt_t;

    typedef struct packed {
        logic [31:0] addr;
        xmd_src_t    src;
        logic        smm;
        logic        writeback;
    } xmd_req_t;

    typedef struct packed {
        logic [12:0] top_of_main_memory_mb;
        logic        fixed_hole_en;
        logic        gfx_en;
        logic [1:0]  gfx_sel;
        logic        compat_smm_en;
        logic        high_smm_segment_en;
        logic        top_smm_segment_en;
        logic [1:0]  smm_size;
        logic [31:0] impedance_compensation_base;
        logic        igd_mode;
        logic [31:0] igd_cfg_base;
        logic [31:0] igd_mmio_base;
        logic        agp_mode;
        logic        agp_mem_en;
        logic [11:0] win_base;
        logic [11:0] win_limit;
        logic [11:0] pf_base;
        logic [11:0] pf_limit;
        logic [31:0] aper_base;
        logic [11:0] aper_mb;
    } xmd_cfg_t;

    typedef struct packed {
        xmd_tgt_t    target;
        logic [31:0] addr;
        logic        terminate;
        logic        refused;
        logic [3:0]  ioapic_unit;
    } xmd_rsp_t;

    localparam xmd_rsp_t RSP_RST = '{
        target:      XMD_TGT_NONE,
        addr:        32'h0000_0000,
        terminate:   1'b0,
        refused:     1'b0,
        ioapic_unit: 4'h0
    };

endpackage : xmd_pkg

`default_nettype wire

/* logic/xmd_range_cmp.sv */
// Inclusive base/limit range comparator.
// Assumes the caller sets an empty or disabled range through i_en.
`default_nettype none

module xmd_range_cmp #(
    parameter int W = 33
) (
    input  wire logic [W-1:0] i_addr,
    input  wire logic [W-1:0] i_base,
    input  wire logic [W-1:0] i_limit,
    input  wire logic         i_en,
    output logic              o_hit
);

    if (W < 2) begin : g_bad_w
        $error("xmd_range_cmp: W too small");
    end

    assign o_hit = i_en && (i_addr >= i_base) && (i_addr <= i_limit);

endmodule // xmd_range_cmp

`default_nettype wire

/* verification/xmd_initiator_model.sv */
// Initiator model: processor bus or downstream port presenting one access at a time.
// Assumes the decoder samples on the rising edge; requests change on the falling edge.
`default_nettype none
module xmd_initiator_model (
    input  wire logic          i_sys_clk,
    output logic               o_valid,
    output xmd_pkg::xmd_req_t  o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_valid = 1'b0;
        o_req   = '0;
    end
    // Released bus shows inverted bits so a stale value can never pass for valid data
    task automatic issue(input xmd_pkg::xmd_req_t r);
        @(negedge i_sys_clk);
        o_valid = 1'b1;
        o_req   = r;
        @(negedge i_sys_clk);
        o_valid = 1'b0;
        o_req   = ~r;
    endtask
endmodule // xmd_initiator_model
`default_nettype wire

/* verification/test_xmd_decoder.sv */
// Self-checking bench for the extended memory decoder.
// Assumes starting map: 256 MB memory, 1 MB graphics, 128 KB top segment, AGP windows at 2 GB and 2.25 GB; later 8 MB graphics, 1 MB top segment.
`default_nettype none
module test_xmd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              valid;
    logic              o_valid;
    xmd_pkg::xmd_req_t req;
    xmd_pkg::xmd_cfg_t cfg = '0;
    xmd_pkg::xmd_rsp_t rsp;
    int                mismatches = 0;
    int                cmp_count = 0;
    logic [31:0]       seed = 32'hE12E;
    logic [31:0]       a;
    always #4 clk = ~clk;
    xmd_initiator_model fsb (.i_sys_clk(clk), .o_valid(valid), .o_req(req));
    xmd_decoder DUT (.i_sys_clk(clk), .i_rst(rst), .i_valid(valid), .i_req(req),
                     .i_cfg(cfg), .o_valid(o_valid), .o_rsp(rsp));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Hole sits inside main memory while enabled
    function automatic logic [2:0] main_tgt(input logic [31:0] ad);
        return (ad >= 32'h00F0_0000 && ad <= 32'h00FF_FFFF) ? 3'h1 : 3'h0;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic [31:0] ad, input logic [1:0] s, input logic sm, wb,
                      input logic [2:0] t, input logic [31:0] ea, input logic [5:0] fl);
        xmd_pkg::xmd_req_t r;
        int n;
        r = '{addr: ad, src: xmd_pkg::xmd_src_t'(s), smm: sm, writeback: wb};
        fsb.issue(r);
        n = 0;
        while (o_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 4) begin
            mismatches++;
            stop_test();
        end
        check({o_valid, rsp.terminate, rsp.refused, rsp.ioapic_unit, rsp.target, rsp.addr},
              {1'b1, fl, t, ea});
    endtask
    initial begin
        cfg.top_of_main_memory_mb = 13'h100;
        cfg.fixed_hole_en = 1'b1;
        cfg.gfx_en = 1'b1;
        cfg.high_smm_segment_en = 1'b1;
        cfg.top_smm_segment_en = 1'b1;
        cfg.impedance_compensation_base = 32'hF000_0000;
        cfg.igd_mmio_base = 32'hE000_0000;
        cfg.igd_cfg_base = 32'hE100_0000;
        cfg.agp_mode = 1'b1;
        cfg.agp_mem_en = 1'b1;
        cfg.win_base = 12'h800;
        cfg.win_limit = 12'h80F;
        cfg.pf_base = 12'h900;
        cfg.pf_limit = 12'h900;
        cfg.aper_base = 32'hA000_0000;
        cfg.aper_mb = 12'h010;
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        go(32'h0050_0000, 0, 0, 0, 3'h0, 32'h0050_0000, 6'h00);
        go(32'h00F8_0000, 0, 0, 0, 3'h1, 32'h00F8_0000, 6'h00);
        go(32'h0FF4_0000, 0, 0, 0, 3'h2, 32'h0FF4_0000, 6'h00);
        go(32'hFEDA_1234, 0, 1, 0, 3'h0, 32'h000A_1234, 6'h00);
        go(32'hFEDA_1234, 0, 0, 0, 3'h5, 32'hFEDA_1234, 6'h20);
        go(32'hFEDA_1234, 0, 0, 1, 3'h0, 32'h000A_1234, 6'h00);
        go(32'hFEDA_1234, 1, 0, 0, 3'h1, 32'hFEDA_1234, 6'h10);
        go(32'h0FEE_0100, 0, 1, 0, 3'h0, 32'h0FEE_0100, 6'h00);
        go(32'h0FED_FFF0, 0, 0, 0, 3'h0, 32'h0FED_FFF0, 6'h00);
        go(32'h0FEE_0000, 2, 0, 0, 3'h1, 32'h0FEE_0000, 6'h10);
        go(32'hF000_0010, 0, 0, 0, 3'h4, 32'hF000_0010, 6'h00);
        go(32'hFEC0_5000, 0, 0, 0, 3'h1, 32'hFEC0_5000, 6'h05);
        go(32'hFED0_0000, 0, 0, 0, 3'h1, 32'hFED0_0000, 6'h00);
        go(32'hFFFF_FFF0, 0, 0, 0, 3'h1, 32'hFFFF_FFF0, 6'h00);
        go(32'h80FF_FFFF, 0, 0, 0, 3'h3, 32'h80FF_FFFF, 6'h00);
        go(32'h8100_0000, 0, 0, 0, 3'h1, 32'h8100_0000, 6'h00);
        go(32'h900F_FFFF, 0, 0, 0, 3'h3, 32'h900F_FFFF, 6'h00);
        go(32'hA000_0040, 0, 0, 0, 3'h0, 32'hA000_0040, 6'h00);
        cfg.agp_mem_en = 1'b0;
        go(32'h8000_0000, 0, 0, 0, 3'h1, 32'h8000_0000, 6'h00);
        cfg.agp_mode = 1'b0;
        cfg.igd_mode = 1'b1;
        go(32'hE000_0100, 0, 0, 0, 3'h2, 32'hE000_0100, 6'h00);
        repeat (20) begin
            seed = xs(seed);
            a = 32'h0010_0000 + (seed % 32'h0FDE_0000);
            go(a, 2'(seed[31:30] % 3), seed[5], 0, main_tgt(a), a, 6'h00);
        end
        go(32'h000B_8000, 0, 0, 0, 3'h2, 32'h000B_8000, 6'h00);
        go(32'h0009_0000, 1, 0, 0, 3'h0, 32'h0009_0000, 6'h00);
        go(32'h000C_0000, 0, 0, 0, 3'h1, 32'h000C_0000, 6'h00);
        cfg.compat_smm_en = 1'b1;
        go(32'h000A_0010, 0, 1, 0, 3'h0, 32'h000A_0010, 6'h00);
        go(32'h000A_0010, 1, 1, 0, 3'h2, 32'h000A_0010, 6'h00);
        // 8 MB graphics and 1 MB top segment move the main memory limit down
        cfg.gfx_sel = 2'h2;
        cfg.smm_size = 2'h3;
        go(32'h0F80_0000, 0, 0, 0, 3'h2, 32'h0F80_0000, 6'h00);
        go(32'h0F70_0000, 0, 0, 0, 3'h5, 32'h0F70_0000, 6'h20);
        go(32'h0F6F_FFFF, 0, 0, 0, 3'h0, 32'h0F6F_FFFF, 6'h00);
        @(negedge clk) rst = 1'b1;
        @(negedge clk);
        check({rsp.target, o_valid}, {xmd_pkg::XMD_TGT_NONE, 1'b0});
        rst = 1'b0;
        go(32'hFEE0_0000, 0, 0, 0, 3'h1, 32'hFEE0_0000, 6'h00);
        stop_test();
    end
endmodule // test_xmd_decoder
`default_nettype wire
